// ### hdl/uart_fbaud_consts.svh
`ifndef UART_FBAUD_CONSTS_SVH
`define UART_FBAUD_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets on the AXI4-Lite bus
// ----------------------------------------------------------------
`define AXI_ADDR_W 5
`define OFS_PATH_ENABLES 5'h00
`define OFS_DIV_LOW 5'h04
`define OFS_DIV_MID 5'h08
`define OFS_DIV_HIGH 5'h0C
`define OFS_TX_FRAC_LO 5'h10
`define OFS_TX_FRAC_HI 5'h14
`define OFS_BAUD_STATUS 5'h18

// ----------------------------------------------------------------
// Field positions, widths and reset values
// ----------------------------------------------------------------
`define TX_EN_BIT 0
`define RX_EN_BIT 1
`define DIV_HIGH_W 3
`define REF_CLK_HZ 48000000
`define ENABLES_RST 2'h0
`define DIV_BYTE_RST 8'h00
`define DIV_HIGH_RST 3'h0
`define FRAC_BYTE_RST 8'h00
`define RX_FRAC_PATTERN 16'h0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### hdl/uart_fbaud_pkg.sv
package uart_fbaud_pkg;

   // ----------------------------------------------------------------
   // Shared types
   // ----------------------------------------------------------------
   typedef logic [7:0] reg_byte_t;
   typedef logic [18:0] divisor_t;
   typedef logic [15:0] frac_pattern_t;
   typedef logic [4:0] reg_addr_t;

   // Write channel sequencing
   typedef enum logic [0:0] {
      WR_WAIT = 1'b0,
      WR_RESP = 1'b1
   } wr_state_t;

   // Read channel sequencing
   typedef enum logic [0:0] {
      RD_IDLE = 1'b0,
      RD_DATA = 1'b1
   } rd_state_t;

endpackage

// ### hdl/baud_tick_gen.sv
`timescale 1ns/10ps
module baud_tick_gen
#(
   parameter int DIV_W = 19,
   parameter int MASK_W = 16,
   parameter int SLOT_W = $clog2(MASK_W)
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic run,
   input wire logic [DIV_W-1:0] divisor,
   input wire logic [MASK_W-1:0] pattern,
   output logic tick_ff,
   output logic [SLOT_W-1:0] slot_ff
);

   logic [DIV_W:0] cnt_ff;
   logic [DIV_W:0] nxt_cnt;
   logic [DIV_W:0] limit;
   logic nxt_tick;
   logic [SLOT_W-1:0] nxt_slot;

   // ----------------------------------------------------------------
   // Bit period counter
   // ----------------------------------------------------------------

   // Period is divisor plus one extra cycle where the pattern bit is set
   assign limit = {1'b0, divisor} + (DIV_W+1)'(pattern[slot_ff]);

   // Count reference cycles, emit one tick per bit period
   always_comb
   begin
      nxt_cnt = cnt_ff;
      nxt_tick = 1'b0;
      nxt_slot = slot_ff;
      if (!run || divisor == '0)
      begin
         nxt_cnt = '0;
         nxt_slot = '0;
      end
      else if (cnt_ff + (DIV_W+1)'(1) >= limit)
      begin
         nxt_cnt = '0;
         nxt_tick = 1'b1;
         nxt_slot = slot_ff + SLOT_W'(1);
      end
      else
      begin
         nxt_cnt = cnt_ff + (DIV_W+1)'(1);
      end
   end

   // Register counter state
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt_ff <= '0;
         tick_ff <= 1'b0;
         slot_ff <= '0;
      end
      else
      begin
         cnt_ff <= nxt_cnt;
         tick_ff <= nxt_tick;
         slot_ff <= nxt_slot;
      end
   end

endmodule

// ### hdl/uart_enable_fractional_baud.sv
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "uart_fbaud_consts.svh"
module uart_enable_fractional_baud
#(
   parameter int DIV_W = 19,
   parameter int MASK_W = 16
)
(
   input wire logic clk,
   input wire logic rst_b,
   // AXI4-Lite write address
   input wire logic awvalid,
   output logic awready,
   input wire uart_fbaud_pkg::reg_addr_t awaddr,
   input wire logic [2:0] awprot,
   // AXI4-Lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // AXI4-Lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read address
   input wire logic arvalid,
   output logic arready,
   input wire uart_fbaud_pkg::reg_addr_t araddr,
   input wire logic [2:0] arprot,
   // AXI4-Lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Serial path controls
   output logic tx_enable,
   output logic rx_enable,
   output logic tx_bit_tick,
   output logic rx_bit_tick
);
   import uart_fbaud_pkg::*;

   localparam int SLOT_W = $clog2(MASK_W);

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------

   // True for any address that holds a register
   function automatic logic is_mapped(input reg_addr_t a);
      return a == `OFS_PATH_ENABLES || a == `OFS_DIV_LOW || a == `OFS_DIV_MID ||
             a == `OFS_DIV_HIGH || a == `OFS_TX_FRAC_LO || a == `OFS_TX_FRAC_HI ||
             a == `OFS_BAUD_STATUS;
   endfunction

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   wr_state_t wr_state_ff, nxt_wr_state;
   rd_state_t rd_state_ff, nxt_rd_state;
   logic aw_held_ff, nxt_aw_held;
   logic w_held_ff, nxt_w_held;
   reg_addr_t waddr_ff, nxt_waddr;
   reg_byte_t wbyte_ff, nxt_wbyte;
   logic wlane_ff, nxt_wlane;
   logic awready_ff, nxt_awready;
   logic wready_ff, nxt_wready;
   logic bvalid_ff, nxt_bvalid;
   logic [1:0] bresp_ff, nxt_bresp;
   logic arready_ff, nxt_arready;
   logic rvalid_ff, nxt_rvalid;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [1:0] rresp_ff, nxt_rresp;
   logic [1:0] enables_ff, nxt_enables;
   reg_byte_t div_low_ff, nxt_div_low;
   reg_byte_t div_mid_ff, nxt_div_mid;
   logic [`DIV_HIGH_W-1:0] div_high_ff, nxt_div_high;
   reg_byte_t frac_lo_ff, nxt_frac_lo;
   reg_byte_t frac_hi_ff, nxt_frac_hi;
   divisor_t divisor;
   frac_pattern_t tx_pattern;
   logic tx_tick;
   logic rx_tick;
   logic [SLOT_W-1:0] tx_slot;
   logic [SLOT_W-1:0] rx_slot;
   logic [31:0] read_word;

   // ----------------------------------------------------------------
   // Baud configuration
   // ----------------------------------------------------------------

   // Assemble divisor and transmit pattern from the byte registers
   assign divisor = {div_high_ff, div_mid_ff, div_low_ff};
   assign tx_pattern = {frac_hi_ff, frac_lo_ff};

   // Transmit bit timing, runs only while transmit is enabled
   baud_tick_gen #(
      .DIV_W(DIV_W),
      .MASK_W(MASK_W),
      .SLOT_W(SLOT_W)
   ) u_tx_baud (
      .clk(clk),
      .rst_b(rst_b),
      .run(enables_ff[`TX_EN_BIT]),
      .divisor(divisor),
      .pattern(tx_pattern),
      .tick_ff(tx_tick),
      .slot_ff(tx_slot)
   );

   // Receive bit timing, runs only while receive is enabled
   baud_tick_gen #(
      .DIV_W(DIV_W),
      .MASK_W(MASK_W),
      .SLOT_W(SLOT_W)
   ) u_rx_baud (
      .clk(clk),
      .rst_b(rst_b),
      .run(enables_ff[`RX_EN_BIT]),
      .divisor(divisor),
      .pattern(`RX_FRAC_PATTERN),
      .tick_ff(rx_tick),
      .slot_ff(rx_slot)
   );

   // ----------------------------------------------------------------
   // Write channel and register file
   // ----------------------------------------------------------------

   // Accept address and data in any order, then update and respond
   always_comb
   begin
      nxt_wr_state = wr_state_ff;
      nxt_aw_held = aw_held_ff;
      nxt_w_held = w_held_ff;
      nxt_waddr = waddr_ff;
      nxt_wbyte = wbyte_ff;
      nxt_wlane = wlane_ff;
      nxt_bvalid = bvalid_ff;
      nxt_bresp = bresp_ff;
      nxt_enables = enables_ff;
      nxt_div_low = div_low_ff;
      nxt_div_mid = div_mid_ff;
      nxt_div_high = div_high_ff;
      nxt_frac_lo = frac_lo_ff;
      nxt_frac_hi = frac_hi_ff;
      if (awvalid && awready_ff)
      begin
         nxt_aw_held = 1'b1;
         nxt_waddr = awaddr;
      end
      if (wvalid && wready_ff)
      begin
         nxt_w_held = 1'b1;
         nxt_wbyte = wdata[7:0];
         nxt_wlane = wstrb[0];
      end
      unique case (wr_state_ff)
         WR_WAIT:
         begin
            if (aw_held_ff && w_held_ff)
            begin
               nxt_aw_held = 1'b0;
               nxt_w_held = 1'b0;
               nxt_bvalid = 1'b1;
               nxt_bresp = is_mapped(waddr_ff) ? `RESP_OKAY : `RESP_SLVERR;
               nxt_wr_state = WR_RESP;
               if (wlane_ff)
               begin
                  // Only defined bits are stored; reserved bits read zero
                  unique case (waddr_ff)
                     `OFS_PATH_ENABLES: nxt_enables = wbyte_ff[1:0];
                     `OFS_DIV_LOW: nxt_div_low = wbyte_ff;
                     `OFS_DIV_MID: nxt_div_mid = wbyte_ff;
                     `OFS_DIV_HIGH: nxt_div_high = wbyte_ff[`DIV_HIGH_W-1:0];
                     `OFS_TX_FRAC_LO: nxt_frac_lo = wbyte_ff;
                     `OFS_TX_FRAC_HI: nxt_frac_hi = wbyte_ff;
                     default: nxt_enables = enables_ff;
                  endcase
               end
            end
         end
         WR_RESP:
         begin
            if (bready)
            begin
               nxt_bvalid = 1'b0;
               nxt_wr_state = WR_WAIT;
            end
         end
      endcase
      nxt_awready = (nxt_wr_state == WR_WAIT) && !nxt_aw_held;
      nxt_wready = (nxt_wr_state == WR_WAIT) && !nxt_w_held;
   end

   // Register write channel and configuration
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wr_state_ff <= WR_WAIT;
         aw_held_ff <= 1'b0;
         w_held_ff <= 1'b0;
         waddr_ff <= '0;
         wbyte_ff <= `DIV_BYTE_RST;
         wlane_ff <= 1'b0;
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= `RESP_OKAY;
         enables_ff <= `ENABLES_RST;
         div_low_ff <= `DIV_BYTE_RST;
         div_mid_ff <= `DIV_BYTE_RST;
         div_high_ff <= `DIV_HIGH_RST;
         frac_lo_ff <= `FRAC_BYTE_RST;
         frac_hi_ff <= `FRAC_BYTE_RST;
      end
      else
      begin
         wr_state_ff <= nxt_wr_state;
         aw_held_ff <= nxt_aw_held;
         w_held_ff <= nxt_w_held;
         waddr_ff <= nxt_waddr;
         wbyte_ff <= nxt_wbyte;
         wlane_ff <= nxt_wlane;
         awready_ff <= nxt_awready;
         wready_ff <= nxt_wready;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
         enables_ff <= nxt_enables;
         div_low_ff <= nxt_div_low;
         div_mid_ff <= nxt_div_mid;
         div_high_ff <= nxt_div_high;
         frac_lo_ff <= nxt_frac_lo;
         frac_hi_ff <= nxt_frac_hi;
      end
   end

   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------

   // Read data selection, status shows live generator state
   always_comb
   begin
      read_word = '0;
      unique case (araddr)
         `OFS_PATH_ENABLES: read_word[1:0] = enables_ff;
         `OFS_DIV_LOW: read_word[7:0] = div_low_ff;
         `OFS_DIV_MID: read_word[7:0] = div_mid_ff;
         `OFS_DIV_HIGH: read_word[`DIV_HIGH_W-1:0] = div_high_ff;
         `OFS_TX_FRAC_LO: read_word[7:0] = frac_lo_ff;
         `OFS_TX_FRAC_HI: read_word[7:0] = frac_hi_ff;
         `OFS_BAUD_STATUS: read_word[7:0] = {tx_slot, rx_slot};
         default: read_word = '0;
      endcase
   end

   // One read at a time, answered the cycle after it is taken
   always_comb
   begin
      nxt_rd_state = rd_state_ff;
      nxt_arready = arready_ff;
      nxt_rvalid = rvalid_ff;
      nxt_rdata = rdata_ff;
      nxt_rresp = rresp_ff;
      unique case (rd_state_ff)
         RD_IDLE:
         begin
            nxt_arready = 1'b1;
            if (arvalid && arready_ff)
            begin
               nxt_arready = 1'b0;
               nxt_rvalid = 1'b1;
               nxt_rdata = read_word;
               nxt_rresp = is_mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
               nxt_rd_state = RD_DATA;
            end
         end
         RD_DATA:
         begin
            if (rready)
            begin
               nxt_rvalid = 1'b0;
               nxt_arready = 1'b1;
               nxt_rd_state = RD_IDLE;
            end
         end
      endcase
   end

   // Register read channel
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rd_state_ff <= RD_IDLE;
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         rdata_ff <= '0;
         rresp_ff <= `RESP_OKAY;
      end
      else
      begin
         rd_state_ff <= nxt_rd_state;
         arready_ff <= nxt_arready;
         rvalid_ff <= nxt_rvalid;
         rdata_ff <= nxt_rdata;
         rresp_ff <= nxt_rresp;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------

   // All outputs come from flip-flops
   assign awready = awready_ff;
   assign wready = wready_ff;
   assign bvalid = bvalid_ff;
   assign bresp = bresp_ff;
   assign arready = arready_ff;
   assign rvalid = rvalid_ff;
   assign rdata = rdata_ff;
   assign rresp = rresp_ff;
   assign tx_enable = enables_ff[`TX_EN_BIT];
   assign rx_enable = enables_ff[`RX_EN_BIT];
   assign tx_bit_tick = tx_tick;
   assign rx_bit_tick = rx_tick;

endmodule

// ### verif/uart_fbaud_assertions.sv
`timescale 1ns/10ps
module uart_fbaud_assertions
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic tx_enable,
   input wire logic rx_enable,
   input wire logic tx_bit_tick,
   input wire logic rx_bit_tick
);
   import uart_fbaud_pkg::*;
   // ----------------------------------------------------------------
   // Bus and tick properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Both write channels taken together, answer two edges later
   sequence s_wr_taken;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence s_resp_late;
      !bvalid ##1 bvalid;
   endsequence
   property p_wr_answer;
      s_wr_taken |=> s_resp_late;
   endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
   property p_rd_answer;
      arvalid && arready |=> rvalid;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
   property p_b_stands;
      bvalid && !bready |=> bvalid && $stable(bresp);
   endproperty
   a_b_stands: assert property (p_b_stands) else $error("write response dropped");
   property p_r_stands;
      rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
   endproperty
   a_r_stands: assert property (p_r_stands) else $error("read data dropped");
   property p_w_blocked;
      bvalid |-> !awready && !wready;
   endproperty
   a_w_blocked: assert property (p_w_blocked) else $error("write taken early");
   property p_ar_blocked;
      rvalid |-> !arready;
   endproperty
   a_ar_blocked: assert property (p_ar_blocked) else $error("read taken early");
   property p_tx_gate;
      tx_bit_tick |-> $past(tx_enable);
   endproperty
   a_tx_gate: assert property (p_tx_gate) else $error("tx tick while off");
   property p_rx_gate;
      rx_bit_tick |-> $past(rx_enable);
   endproperty
   a_rx_gate: assert property (p_rx_gate) else $error("rx tick while off");
   property p_en_by_write;
      $changed(tx_enable) || $changed(rx_enable) |-> $rose(bvalid);
   endproperty
   a_en_by_write: assert property (p_en_by_write) else $error("enable moved alone");
endmodule
bind uart_enable_fractional_baud uart_fbaud_assertions u_chk (.clk(clk), .rst_b(rst_b),
   .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
   .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
   .rready(rready), .rdata(rdata), .rresp(rresp), .tx_enable(tx_enable),
   .rx_enable(rx_enable), .tx_bit_tick(tx_bit_tick), .rx_bit_tick(rx_bit_tick));

// ### verif/tb_uart_enable_fractional_baud.sv
`timescale 1ns/10ps
`include "uart_fbaud_consts.svh"
module tb_uart_enable_fractional_baud;
   import uart_fbaud_pkg::*;
   // ----------------------------------------------------------------
   // Stimulus and bus tasks
   // ----------------------------------------------------------------
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   reg_addr_t awaddr = 5'h00, araddr = 5'h00;
   logic [2:0] awprot = 3'h0, arprot = 3'h0;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic tx_enable, rx_enable, tx_bit_tick, rx_bit_tick;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata, data;
   int n_errors = 0, total_checks = 0, cycles = 0, span_c, nt, nr;
   reg_addr_t offs[7] = '{`OFS_PATH_ENABLES, `OFS_DIV_LOW, `OFS_DIV_MID, `OFS_DIV_HIGH,
      `OFS_TX_FRAC_LO, `OFS_TX_FRAC_HI, `OFS_BAUD_STATUS};
   logic [7:0] wv[6] = '{8'h00, 8'hA5, 8'h5A, 8'h07, 8'h6D, 8'h0B};
   logic [7:0] ev[6] = '{8'h00, 8'hA5, 8'h5A, 8'h07, 8'h6D, 8'h0B};

   // Clock at 40 MHz
   always #12.5 clk = ~clk;

   uart_enable_fractional_baud dut (.clk(clk), .rst_b(rst_b), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .awprot(awprot), .wvalid(wvalid), .wready(wready),
      .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .tx_enable(tx_enable), .rx_enable(rx_enable), .tx_bit_tick(tx_bit_tick),
      .rx_bit_tick(rx_bit_tick));

   task automatic print_verdict();
      $display("Mismatches %0d, comparisons %0d", n_errors, total_checks);
      if (n_errors == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // Write one byte; response ready offered with the request, one edge after the last call
   task automatic axi_wr(input reg_addr_t a, input logic [7:0] d);
      @(posedge clk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= {24'h000000, d};
      wstrb <= 4'hF;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever
      begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready)
         begin
            resp = bresp;
            bready <= 1'b0;
            break;
         end
      end
   endtask

   // Read one word; data ready offered with the request
   task automatic axi_rd(input reg_addr_t a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever
      begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready)
         begin
            data = rdata;
            resp = rresp;
            rready <= 1'b0;
            break;
         end
      end
   endtask

   // Cycles spanned by sixteen bit periods after a first tick
   task automatic spans(input bit rx);
      int k;
      k = 0;
      span_c = 0;
      do @(posedge clk); while ((rx ? rx_bit_tick : tx_bit_tick) !== 1'b1);
      while (k < 16)
      begin
         @(posedge clk);
         span_c++;
         if ((rx ? rx_bit_tick : tx_bit_tick) === 1'b1) k++;
      end
   endtask

   task automatic count_ticks(input int n);
      nt = 0;
      nr = 0;
      repeat (n)
      begin
         @(posedge clk);
         nt += (tx_bit_tick === 1'b1);
         nr += (rx_bit_tick === 1'b1);
      end
   endtask

   // Hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         n_errors++;
         print_verdict();
      end
   end

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      foreach (offs[i])
      begin
         axi_rd(offs[i]);
         chk(data, 32'h00000000);
         chk(resp, `RESP_OKAY);
      end
      // Readback, reserved bits kept zero by software
      for (int i = 0; i < 6; i++)
      begin
         axi_wr(offs[i], wv[i]);
         chk(resp, `RESP_OKAY);
         axi_rd(offs[i]);
         chk(data, {24'h000000, ev[i]});
      end
      axi_wr(5'h1C, 8'h55);
      chk(resp, `RESP_SLVERR);
      axi_rd(5'h1C);
      chk(resp, `RESP_SLVERR);
      chk(data, 32'h00000000);
      // Divisor 259 over two bytes, paths still off
      axi_wr(`OFS_DIV_LOW, 8'h03);
      axi_wr(`OFS_DIV_MID, 8'h01);
      axi_wr(`OFS_DIV_HIGH, 8'h00);
      count_ticks(600);
      chk(nt, 0);
      chk(nr, 0);
      axi_wr(`OFS_PATH_ENABLES, 8'h01);
      chk({rx_enable, tx_enable}, 2'b01);
      spans(1'b0);
      chk(span_c, 16 * 259 + 8);
      axi_wr(`OFS_PATH_ENABLES, 8'h03);
      chk({rx_enable, tx_enable}, 2'b11);
      axi_rd(`OFS_PATH_ENABLES);
      chk(data, 32'h00000003);
      spans(1'b1);
      chk(span_c, 16 * 259);
      axi_wr(`OFS_PATH_ENABLES, 8'h02);
      count_ticks(518);
      chk(nt, 0);
      chk(nr, 2);
      axi_wr(`OFS_PATH_ENABLES, 8'h00);
      count_ticks(518);
      chk(nr, 0);
      print_verdict();
   end
endmodule
